/* File: hdl/dofs_pkg.sv */
/*
  Constants and types for the digital output function selector.
  Assumes one system clock; condition flags arrive from the drive core.
*/
package dofs_pkg;

  // ----------------------------------------
  // Widths and terminal order
  // ----------------------------------------
  localparam int SEL_W = 6;
  localparam int TERM_N = 4;
  localparam int T_RELAY_A = 0;
  localparam int T_RELAY_B = 1;
  localparam int T_COLL_A = 2;
  localparam int T_FAST = 3;
  localparam int Z_CNT_W = 24;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [3:0][7:0] OFS_SEL = {8'h0c, 8'h08, 8'h04, 8'h00};
  localparam logic [7:0] OFS_FAST_TYPE = 8'h10;
  localparam logic [7:0] OFS_VIRT = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // Virtual bit fields: one nibble per fieldbus, one bit per terminal
  localparam int VIRT_MODBUS_LSB = 0;
  localparam int VIRT_PROFI_LSB = 4;
  localparam int VIRT_ETH_LSB = 8;
  localparam int VIRT_ECAT_LSB = 12;

  // Status word fields
  localparam int STAT_TERM_LSB = 0;
  localparam int STAT_TYPE_BIT = 4;
  localparam int STAT_Z_BIT = 5;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [3:0][5:0] RST_SEL = {6'h00, 6'h00, 6'h05, 6'h01};
  localparam logic FAST_PULSE = 1'b0;
  localparam logic FAST_ONOFF = 1'b1;
  localparam logic RST_FAST_TYPE = FAST_PULSE;

  // ----------------------------------------
  // Function codes
  // ----------------------------------------
  localparam logic [5:0] C_OFF = 6'h00;
  localparam logic [5:0] C_RUN = 6'h01;
  localparam logic [5:0] C_FWD = 6'h02;
  localparam logic [5:0] C_REV = 6'h03;
  localparam logic [5:0] C_JOG = 6'h04;
  localparam logic [5:0] C_FAULT = 6'h05;
  localparam logic [5:0] C_FDT_A = 6'h06;
  localparam logic [5:0] C_FDT_B = 6'h07;
  localparam logic [5:0] C_REACHED = 6'h08;
  localparam logic [5:0] C_ZERO_SPD = 6'h09;
  localparam logic [5:0] C_UPPER = 6'h0a;
  localparam logic [5:0] C_LOWER = 6'h0b;
  localparam logic [5:0] C_READY = 6'h0c;
  localparam logic [5:0] C_PREEXC = 6'h0d;
  localparam logic [5:0] C_OVLD = 6'h0e;
  localparam logic [5:0] C_UNLD = 6'h0f;
  localparam logic [5:0] C_STAGE = 6'h10;
  localparam logic [5:0] C_CYCLE = 6'h11;
  localparam logic [5:0] C_V_MODBUS = 6'h17;
  localparam logic [5:0] C_V_PROFI = 6'h18;
  localparam logic [5:0] C_V_ETH = 6'h19;
  localparam logic [5:0] C_DC_BUS = 6'h1a;
  localparam logic [5:0] C_Z_PULSE = 6'h1b;
  localparam logic [5:0] C_SUPERPOS = 6'h1c;
  localparam logic [5:0] C_STO = 6'h1d;
  localparam logic [5:0] C_POS_DONE = 6'h1e;
  localparam logic [5:0] C_ZERO_DONE = 6'h1f;
  localparam logic [5:0] C_DIV_DONE = 6'h20;
  localparam logic [5:0] C_TQ_LIMIT = 6'h21;
  localparam logic [5:0] C_V_ECAT = 6'h22;
  localparam logic [5:0] C_SWITCHED = 6'h24;
  localparam logic [5:0] C_ANY_FREQ = 6'h25;
  localparam logic [5:0] C_CARD_A = 6'h29;
  localparam logic [5:0] C_CARD_B = 6'h2a;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int Z_HOLD_MS = 10;
  localparam int Z_HOLD_CYCLES = Z_HOLD_MS * (CLK_HZ / 1000);

  // ----------------------------------------
  // Condition flags from the drive core
  // ----------------------------------------
  typedef struct packed {
    logic running;
    logic run_fwd;
    logic run_rev;
    logic jogging;
    logic fault;
    logic freq_level_detect_a;
    logic freq_level_detect_b;
    logic freq_reached;
    logic out_freq_zero;
    logic ref_freq_zero;
    logic at_upper_limit;
    logic at_lower_limit;
    logic main_power_ok;
    logic ctrl_power_ok;
    logic protect_active;
    logic ready;
    logic pre_exciting;
    logic overload_alarm;
    logic underload_alarm;
    logic plc_stage_done;
    logic plc_cycle_done;
    logic dc_bus_ok;
    logic pulse_superpose;
    logic safe_torque_off_trip;
    logic positioning_done;
    logic zeroing_done;
    logic division_done;
    logic torque_freq_limit;
    logic mode_switch_done;
    logic any_freq_reached;
  } dofs_cond_type;

  // ----------------------------------------
  // Whole state of the selector
  // ----------------------------------------
  typedef struct packed {
    logic [3:0][5:0] sel;
    logic fast_type;
    logic [15:0] virt;
    logic [1:0] idx_sync;
    logic idx_prev;
    logic [1:0] card_a_sync;
    logic [1:0] card_b_sync;
    logic [Z_CNT_W-1:0] z_cnt;
    logic [3:0] term;
    logic [31:0] rdata;
  } dofs_state_type;

endpackage

/* File: hdl/dofs_selector.sv */
/*
  Digital output function selector: four terminals, each driven by the
  condition that its function code names.
  Assumes condition flags and the pulse generator run on clk_i, while the
  encoder index and card outputs arrive asynchronously.
*/
// The address-and-strobe port and the register offsets were decided locally.
// What this block does
// RULE1 - Four independent selectors; one code may serve several terminals.
// RULE2 - Fast terminal works as pulse output or plain on/off output.
// RULE3 - Code 0 leaves the terminal inactive.
// RULE4 - Codes 1-4: running, forward, reverse, jogging with frequency output.
// RULE5 - Code 5 follows the drive fault.
// RULE6 - Codes 6-8 pass frequency level a, level b, frequency reached.
// RULE7 - Code 9 on only when output and reference frequency both zero.
// RULE8 - Codes 10 and 11: upper or lower limit frequency reached.
// RULE9 - Code 12: both powers up, no protection, drive ready.
// RULE10 - Code 13 on while pre-exciting the motor.
// RULE11 - Codes 14 and 15 pass overload and underload pre-alarms.
// RULE12 - Codes 16 and 17: sequencer stage or cycle completed.
// RULE13 - Codes 23, 24, 25, 34 follow fieldbus virtual bits.
// RULE14 - Code 26 on while DC bus is above undervoltage.
// RULE15 - Code 27 on at encoder index, off 10 ms later.
// RULE16 - Code 28 on while pulse superposition is valid.
// RULE17 - Code 29 on when safe torque off has tripped.
// RULE18 - Codes 30-32: positioning, spindle zeroing, scale division done.
// RULE19 - Code 33 on while frequency is limited in torque control.
// RULE20 - Code 36 on once speed/position switch-over completed.
// RULE21 - Code 37 on while ramp reference exceeds detection value.
// RULE22 - Codes 41 and 42 pass card collector outputs a and b.
// RULE23 - Reserved and unlisted codes leave the terminal inactive.
// RULE24 - Reset selectors: relay a 1, relay b 5, others 0.
// RULE25 - Fast type 0 means pulse output, 1 means on/off output.
`timescale 1ns/100ps

module dofs_selector #(
  parameter int Z_HOLD = dofs_pkg::Z_HOLD_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire dofs_pkg::dofs_cond_type cond_i,
  input wire logic pulse_gen_i,
  input wire logic encoder_index_i,
  input wire logic card_collector_out_a_i,
  input wire logic card_collector_out_b_i,
  output logic relay_out_a_o,
  output logic relay_out_b_o,
  output logic collector_out_a_o,
  output logic fast_pulse_out_o
);

  localparam dofs_pkg::dofs_state_type RST_STATE = '{
    sel: dofs_pkg::RST_SEL,
    fast_type: dofs_pkg::RST_FAST_TYPE,
    default: '0
  };
  localparam logic [dofs_pkg::Z_CNT_W-1:0] Z_LOAD = Z_HOLD[dofs_pkg::Z_CNT_W-1:0];

  dofs_pkg::dofs_state_type state;
  dofs_pkg::dofs_state_type next_state;
  logic z_on;
  logic idx_rise;

  // ----------------------------------------
  // Function decode for one terminal
  // ----------------------------------------
  function automatic logic dofs_pick(
    input logic [5:0] code,
    input dofs_pkg::dofs_cond_type c,
    input logic [3:0] vb,
    input logic zp,
    input logic ca,
    input logic cb
  );
    logic pick;
    pick = 1'b0;
    case (code)
      dofs_pkg::C_OFF: pick = 1'b0; // RULE3
      dofs_pkg::C_RUN: pick = c.running & ~c.out_freq_zero; // RULE4
      dofs_pkg::C_FWD: pick = c.run_fwd & ~c.out_freq_zero; // RULE4
      dofs_pkg::C_REV: pick = c.run_rev & ~c.out_freq_zero; // RULE4
      dofs_pkg::C_JOG: pick = c.jogging & ~c.out_freq_zero; // RULE4
      dofs_pkg::C_FAULT: pick = c.fault; // RULE5
      dofs_pkg::C_FDT_A: pick = c.freq_level_detect_a; // RULE6
      dofs_pkg::C_FDT_B: pick = c.freq_level_detect_b; // RULE6
      dofs_pkg::C_REACHED: pick = c.freq_reached; // RULE6
      dofs_pkg::C_ZERO_SPD: pick = c.out_freq_zero & c.ref_freq_zero; // RULE7
      dofs_pkg::C_UPPER: pick = c.at_upper_limit; // RULE8
      dofs_pkg::C_LOWER: pick = c.at_lower_limit; // RULE8
      dofs_pkg::C_READY: begin
        // Both supplies up, nothing tripped, core says ready
        pick = c.main_power_ok & c.ctrl_power_ok & ~c.protect_active & c.ready; // RULE9
      end
      dofs_pkg::C_PREEXC: pick = c.pre_exciting; // RULE10
      dofs_pkg::C_OVLD: pick = c.overload_alarm; // RULE11
      dofs_pkg::C_UNLD: pick = c.underload_alarm; // RULE11
      dofs_pkg::C_STAGE: pick = c.plc_stage_done; // RULE12
      dofs_pkg::C_CYCLE: pick = c.plc_cycle_done; // RULE12
      dofs_pkg::C_V_MODBUS: pick = vb[0]; // RULE13
      dofs_pkg::C_V_PROFI: pick = vb[1]; // RULE13
      dofs_pkg::C_V_ETH: pick = vb[2]; // RULE13
      dofs_pkg::C_V_ECAT: pick = vb[3]; // RULE13
      dofs_pkg::C_DC_BUS: pick = c.dc_bus_ok; // RULE14
      dofs_pkg::C_Z_PULSE: pick = zp; // RULE15
      dofs_pkg::C_SUPERPOS: pick = c.pulse_superpose; // RULE16
      dofs_pkg::C_STO: pick = c.safe_torque_off_trip; // RULE17
      dofs_pkg::C_POS_DONE: pick = c.positioning_done; // RULE18
      dofs_pkg::C_ZERO_DONE: pick = c.zeroing_done; // RULE18
      dofs_pkg::C_DIV_DONE: pick = c.division_done; // RULE18
      dofs_pkg::C_TQ_LIMIT: pick = c.torque_freq_limit; // RULE19
      dofs_pkg::C_SWITCHED: pick = c.mode_switch_done; // RULE20
      dofs_pkg::C_ANY_FREQ: pick = c.any_freq_reached; // RULE21
      dofs_pkg::C_CARD_A: pick = ca; // RULE22
      dofs_pkg::C_CARD_B: pick = cb; // RULE22
      default: pick = 1'b0; // RULE23
    endcase
    return pick;
  endfunction

  // ----------------------------------------
  // Index pulse timing
  // ----------------------------------------
  // Edge seen only on the second synchroniser stage
  assign idx_rise = state.idx_sync[1] & ~state.idx_prev;
  assign z_on = (state.z_cnt != '0);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Register writes, synchronisers, index timer, terminal outputs, read data
  always_comb begin
    logic [3:0] vb;
    logic sel_hit;
    vb = '0;
    sel_hit = 1'b0;
    next_state = state;

    // Register writes; unmapped addresses are ignored
    if (wr_i) begin
      for (int t = 0; t < dofs_pkg::TERM_N; t++) begin
        if (addr_i == dofs_pkg::OFS_SEL[t]) begin
          next_state.sel[t] = wdata_i[dofs_pkg::SEL_W-1:0]; // RULE1
        end
      end
      if (addr_i == dofs_pkg::OFS_FAST_TYPE) begin
        next_state.fast_type = wdata_i[0]; // RULE25
      end
      if (addr_i == dofs_pkg::OFS_VIRT) begin
        next_state.virt = wdata_i[15:0]; // RULE13
      end
    end

    // Two-stage synchronisers for asynchronous inputs
    next_state.idx_sync = {state.idx_sync[0], encoder_index_i};
    next_state.idx_prev = state.idx_sync[1];
    next_state.card_a_sync = {state.card_a_sync[0], card_collector_out_a_i};
    next_state.card_b_sync = {state.card_b_sync[0], card_collector_out_b_i};

    // Index hold timer, retriggered by each new pulse
    if (idx_rise) begin
      next_state.z_cnt = Z_LOAD; // RULE15
    end else if (z_on) begin
      next_state.z_cnt = state.z_cnt - 1'b1; // RULE15
    end

    // Each terminal decodes its own selector
    for (int t = 0; t < dofs_pkg::TERM_N; t++) begin
      vb = {state.virt[dofs_pkg::VIRT_ECAT_LSB + t],
            state.virt[dofs_pkg::VIRT_ETH_LSB + t],
            state.virt[dofs_pkg::VIRT_PROFI_LSB + t],
            state.virt[dofs_pkg::VIRT_MODBUS_LSB + t]};
      next_state.term[t] = dofs_pick(state.sel[t], cond_i, vb, z_on,
                                     state.card_a_sync[1], state.card_b_sync[1]); // RULE1
    end

    // Fast terminal in pulse mode carries the pulse generator
    if (state.fast_type == dofs_pkg::FAST_PULSE) begin
      next_state.term[dofs_pkg::T_FAST] = pulse_gen_i; // RULE2
    end

    // Read data stand for one cycle only
    next_state.rdata = '0;
    if (rd_i) begin
      for (int t = 0; t < dofs_pkg::TERM_N; t++) begin
        if (addr_i == dofs_pkg::OFS_SEL[t]) begin
          next_state.rdata[dofs_pkg::SEL_W-1:0] = state.sel[t];
          sel_hit = 1'b1;
        end
      end
      if (!sel_hit) begin
        case (addr_i)
          dofs_pkg::OFS_FAST_TYPE: next_state.rdata[0] = state.fast_type;
          dofs_pkg::OFS_VIRT: next_state.rdata[15:0] = state.virt;
          dofs_pkg::OFS_STATUS: begin
            next_state.rdata[dofs_pkg::STAT_TERM_LSB +: 4] = state.term;
            next_state.rdata[dofs_pkg::STAT_TYPE_BIT] = state.fast_type;
            next_state.rdata[dofs_pkg::STAT_Z_BIT] = z_on;
          end
          default: next_state.rdata = '0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Synchronous reset loads the default selectors
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= RST_STATE; // RULE24
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from flip-flops
  assign relay_out_a_o = state.term[dofs_pkg::T_RELAY_A];
  assign relay_out_b_o = state.term[dofs_pkg::T_RELAY_B];
  assign collector_out_a_o = state.term[dofs_pkg::T_COLL_A];
  assign fast_pulse_out_o = state.term[dofs_pkg::T_FAST];
  assign rdata_o = state.rdata;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb_main @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  // Code 0 keeps relay a off
  zero_code_off_a: assert property ( // RULE3
    state.sel[dofs_pkg::T_RELAY_A] == dofs_pkg::C_OFF |=> !relay_out_a_o
  ) else $error("relay a active with code 0");

  // Running code follows running with frequency output
  run_follow_a: assert property ( // RULE4
    state.sel[dofs_pkg::T_COLL_A] == dofs_pkg::C_RUN
      |=> collector_out_a_o == $past(cond_i.running & ~cond_i.out_freq_zero)
  ) else $error("collector a does not follow running");

  // Fault code follows the fault flag
  fault_follow_a: assert property ( // RULE5
    state.sel[dofs_pkg::T_RELAY_B] == dofs_pkg::C_FAULT
      |=> relay_out_b_o == $past(cond_i.fault)
  ) else $error("relay b does not follow fault");

  // Zero speed needs both frequencies zero
  zero_speed_a: assert property ( // RULE7
    state.sel[dofs_pkg::T_COLL_A] == dofs_pkg::C_ZERO_SPD
      |=> collector_out_a_o == $past(cond_i.out_freq_zero & cond_i.ref_freq_zero)
  ) else $error("zero speed output wrong");

  // Ready stays off while protection acts
  ready_run_a: assert property ( // RULE9
    state.sel[dofs_pkg::T_RELAY_A] == dofs_pkg::C_READY && cond_i.protect_active
      |=> !relay_out_a_o
  ) else $error("ready output on while protection acts");

  // Virtual bit drives relay a
  virt_bit_a: assert property ( // RULE13
    state.sel[dofs_pkg::T_RELAY_A] == dofs_pkg::C_V_MODBUS
      |=> relay_out_a_o == $past(state.virt[dofs_pkg::VIRT_MODBUS_LSB])
  ) else $error("relay a does not follow virtual bit");

  // Index edge loads the full hold count, then counts down
  z_hold_load_a: assert property ( // RULE15
    idx_rise |=> state.z_cnt == Z_LOAD ##1 state.z_cnt == Z_LOAD - 1'b1
  ) else $error("index hold count not loaded");

  // Timer runs out one cycle after a count of 1 without a new edge
  z_hold_end_a: assert property ( // RULE15
    state.z_cnt == 1 && !idx_rise |=> !z_on
  ) else $error("index hold does not end");

  // Reserved codes 35, 38-40 and 43-63 keep relay a off
  reserved_code_a: assert property ( // RULE23
    state.sel[dofs_pkg::T_RELAY_A] inside {6'h23, [6'h26:6'h28], [6'h2b:6'h3f]}
      |=> !relay_out_a_o
  ) else $error("reserved code drives relay a");

  // Fast terminal in pulse mode carries the generator
  pulse_mode_a: assert property ( // RULE25
    state.fast_type == dofs_pkg::FAST_PULSE
      |=> fast_pulse_out_o == $past(pulse_gen_i)
  ) else $error("pulse mode does not pass generator");

  // Selectors come out of reset at their defaults
  reset_defaults_a: assert property ( // RULE24
    $past(reset_i)
      |-> state.sel == dofs_pkg::RST_SEL && state.fast_type == dofs_pkg::FAST_PULSE
  ) else $error("reset defaults wrong");

  // Forward code needs forward running with frequency output
  fwd_follow_a: assert property ( // RULE4
    state.sel[dofs_pkg::T_RELAY_B] == dofs_pkg::C_FWD
      |=> relay_out_b_o == $past(cond_i.run_fwd & ~cond_i.out_freq_zero)
  ) else $error("relay b does not follow forward running");

  // Level detect a passes straight through
  fdt_pass_a: assert property ( // RULE6
    state.sel[dofs_pkg::T_RELAY_A] == dofs_pkg::C_FDT_A
      |=> relay_out_a_o == $past(cond_i.freq_level_detect_a)
  ) else $error("relay a does not follow level detect a");

  // Safe torque off trip drives relay b
  sto_trip_a: assert property ( // RULE17
    state.sel[dofs_pkg::T_RELAY_B] == dofs_pkg::C_STO
      |=> relay_out_b_o == $past(cond_i.safe_torque_off_trip)
  ) else $error("relay b does not follow torque off trip");

  // Card output b reaches collector a after its synchroniser
  card_pass_a: assert property ( // RULE22
    state.sel[dofs_pkg::T_COLL_A] == dofs_pkg::C_CARD_B
      |=> collector_out_a_o == $past(state.card_b_sync[1])
  ) else $error("collector a does not follow card output b");

  // On/off mode with code 0 keeps the fast terminal off
  onoff_mode_a: assert property ( // RULE2
    state.fast_type == dofs_pkg::FAST_ONOFF && state.sel[dofs_pkg::T_FAST] == dofs_pkg::C_OFF
      |=> !fast_pulse_out_o
  ) else $error("fast terminal active with code 0");

  // DC bus code on the fast terminal in on/off mode
  dc_bus_fast_a: assert property ( // RULE14
    state.fast_type == dofs_pkg::FAST_ONOFF && state.sel[dofs_pkg::T_FAST] == dofs_pkg::C_DC_BUS
      |=> fast_pulse_out_o == $past(cond_i.dc_bus_ok)
  ) else $error("fast terminal does not follow dc bus");

  // Index code shows the hold window
  z_pulse_out_a: assert property ( // RULE15
    state.sel[dofs_pkg::T_RELAY_A] == dofs_pkg::C_Z_PULSE
      |=> relay_out_a_o == $past(z_on)
  ) else $error("relay a does not follow index hold");

  // Selector read returns the stored code in the next cycle
  sel_readback_a: assert property ( // RULE1
    rd_i && addr_i == dofs_pkg::OFS_SEL[dofs_pkg::T_RELAY_A]
      |=> rdata_o == {26'h0, $past(state.sel[dofs_pkg::T_RELAY_A])}
  ) else $error("selector read data wrong");

endmodule

/* File: test/dofs_load_model.sv */
/*
  Load model for the four output terminals: only the fast terminal's pulse load is modelled.
  Assumes terminal levels are active high and share the system clock.
*/
`timescale 1ns/100ps

module dofs_load_model (
  input wire logic clk_i,
  input wire logic [3:0] term_i,
  output logic [15:0] pulse_count_o
);
  logic fast_prev;

  // ----------------------------------------
  // Fast pulse load
  // ----------------------------------------
  // Start from a known count; the bench looks only at differences
  initial begin
    pulse_count_o = 16'h0000;
    fast_prev = 1'b0;
  end

  // Counts rising edges that the pulse load receives
  always @(posedge clk_i) begin
    if (term_i[dofs_pkg::T_FAST] === 1'b1 && fast_prev === 1'b0) begin
      pulse_count_o <= pulse_count_o + 16'h0001;
    end
    fast_prev <= term_i[dofs_pkg::T_FAST];
  end
endmodule

/* File: test/tb.sv */
/*
  Self-checking bench for the digital output function selector.
  Assumes the register port answers a read one cycle after the strobe.
*/
`timescale 1ns/100ps

module tb;
  localparam int ZH = 20;
  logic clk_i;
  logic reset_i;
  logic [7:0] addr_i;
  logic [31:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [31:0] rdata_o;
  dofs_pkg::dofs_cond_type cond_i;
  logic pulse_gen_i;
  logic encoder_index_i;
  logic card_a;
  logic card_b;
  logic [3:0] outs;
  logic [15:0] pulse_count;
  logic [15:0] pc0;
  logic [31:0] rd_val;
  logic [15:0] virt;
  logic [5:0] sel [4];
  logic [3:0] ex;
  logic pg_prev;
  int i;
  int k;
  int t;
  int n;
  int cnt;
  int rises;
  int n_fail;
  int compares;

  dofs_selector #(.Z_HOLD(ZH)) DUT (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .cond_i(cond_i),
    .pulse_gen_i(pulse_gen_i),
    .encoder_index_i(encoder_index_i),
    .card_collector_out_a_i(card_a),
    .card_collector_out_b_i(card_b),
    .relay_out_a_o(outs[0]),
    .relay_out_b_o(outs[1]),
    .collector_out_a_o(outs[2]),
    .fast_pulse_out_o(outs[3])
  );

  dofs_load_model LOAD (
    .clk_i(clk_i),
    .term_i(outs),
    .pulse_count_o(pulse_count)
  );

  // ----------------------------------------
  // Clock and helpers
  // ----------------------------------------
  // 125 MHz system clock
  always #4 clk_i = ~clk_i;

  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write strobe launched just after an edge
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    rd_val = rdata_o;
  endtask

  // Terminal level that a code must give under the present conditions
  function automatic logic exp_term(input logic [5:0] code, input int tn);
    logic mv;
    mv = !cond_i.out_freq_zero;
    case (code)
      6'h01: return cond_i.running && mv;
      6'h02: return cond_i.run_fwd && mv;
      6'h03: return cond_i.run_rev && mv;
      6'h04: return cond_i.jogging && mv;
      6'h05: return cond_i.fault;
      6'h06: return cond_i.freq_level_detect_a;
      6'h07: return cond_i.freq_level_detect_b;
      6'h08: return cond_i.freq_reached;
      6'h09: return cond_i.out_freq_zero && cond_i.ref_freq_zero;
      6'h0a: return cond_i.at_upper_limit;
      6'h0b: return cond_i.at_lower_limit;
      6'h0c: return cond_i.main_power_ok && cond_i.ctrl_power_ok && !cond_i.protect_active
        && cond_i.ready;
      6'h0d: return cond_i.pre_exciting;
      6'h0e: return cond_i.overload_alarm;
      6'h0f: return cond_i.underload_alarm;
      6'h10: return cond_i.plc_stage_done;
      6'h11: return cond_i.plc_cycle_done;
      6'h17: return virt[tn];
      6'h18: return virt[4+tn];
      6'h19: return virt[8+tn];
      6'h1a: return cond_i.dc_bus_ok;
      6'h1c: return cond_i.pulse_superpose;
      6'h1d: return cond_i.safe_torque_off_trip;
      6'h1e: return cond_i.positioning_done;
      6'h1f: return cond_i.zeroing_done;
      6'h20: return cond_i.division_done;
      6'h21: return cond_i.torque_freq_limit;
      6'h22: return virt[12+tn];
      6'h24: return cond_i.mode_switch_done;
      6'h25: return cond_i.any_freq_reached;
      6'h29: return card_a;
      6'h2a: return card_b;
      default: return 1'b0;
    endcase
  endfunction

  // New conditions, card levels and virtual bits; k picks zeros, ones or random
  task automatic shake(input int mode);
    @(posedge clk_i);
    cond_i <= (mode == 0) ? 30'h0 : (mode == 1) ? 30'h3fffffff : 30'($urandom);
    card_a <= (mode == 2) ? 1'($urandom) : mode[0];
    card_b <= (mode == 2) ? 1'($urandom) : mode[0];
    virt = (mode == 2) ? 16'($urandom) : {16{mode[0]}};
    bus_wr(dofs_pkg::OFS_VIRT, {16'h0000, virt});
  endtask

  // Let the synchronisers settle, then compare all four terminals
  task automatic check_all();
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    for (int j = 0; j < 4; j++) begin
      ex[j] = exp_term(sel[j], j);
      chk_bit($sformatf("terminal %0d code %0d", j, sel[j]), ex[j], outs[j]);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  // The whole run needs about 4300 cycles
  initial begin
    #400000;
    n_fail++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  // Reset, defaults, pulse mode, index hold, code sweep, random mix
  initial begin
    void'($urandom(32'hbd208528));
    clk_i = 1'b0;
    reset_i = 1'b1;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    cond_i = '0;
    pulse_gen_i = 1'b0;
    encoder_index_i = 1'b0;
    card_a = 1'b0;
    card_b = 1'b0;
    virt = 16'h0000;
    n_fail = 0;
    compares = 0;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    chk_word("outputs after reset", 32'h0, {28'h0, outs});
    for (t = 0; t < 4; t++) begin
      bus_rd(dofs_pkg::OFS_SEL[t]);
      chk_word("selector reset", (t == 0) ? 32'h1 : (t == 1) ? 32'h5 : 32'h0, rd_val);
    end
    bus_rd(dofs_pkg::OFS_FAST_TYPE);
    chk_word("fast type reset", 32'h0, rd_val);
    bus_rd(8'h1c);
    chk_word("unmapped read", 32'h0, rd_val);
    // Pulse mode: fast terminal copies the generator, selector is 0
    pc0 = pulse_count;
    rises = 0;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_i);
      pg_prev = pulse_gen_i;
      pulse_gen_i <= 1'($urandom);
      @(negedge clk_i);
      chk_bit("fast pulse copy", pg_prev, outs[3]);
      rises += (pulse_gen_i && !pg_prev) ? 1 : 0;
    end
    @(posedge clk_i);
    pulse_gen_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk_word("pulse count", 32'(rises), {16'h0, 16'(pulse_count - pc0)});
    bus_wr(dofs_pkg::OFS_FAST_TYPE, 32'hfffffffe | 32'h1);
    // Index hold on two terminals at once
    bus_wr(dofs_pkg::OFS_SEL[0], 32'd27);
    bus_wr(dofs_pkg::OFS_SEL[1], 32'd27);
    @(posedge clk_i);
    encoder_index_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    encoder_index_i <= 1'b0;
    for (n = 0; n < 8 && outs[0] !== 1'b1; n++) @(negedge clk_i);
    chk_bit("index pair", outs[0], outs[1]);
    for (cnt = 0; cnt < 2 * ZH && outs[0] === 1'b1; cnt++) @(negedge clk_i);
    chk_word("index hold cycles", 32'(ZH), 32'(cnt));
    // Every code on all four terminals: zeros, ones, random
    for (i = 0; i < 64; i++) begin
      for (t = 0; t < 4; t++) begin
        sel[t] = 6'(i);
        bus_wr(dofs_pkg::OFS_SEL[t], {26'($urandom), sel[t]});
      end
      bus_rd(dofs_pkg::OFS_SEL[0]);
      chk_word("selector readback", {26'h0, sel[0]}, rd_val);
      for (k = 0; k < 3; k++) begin
        shake(k);
        check_all();
      end
      bus_rd(dofs_pkg::OFS_STATUS);
      chk_word("status word", {26'h0, 2'b01, ex}, rd_val);
    end
    // Random codes per terminal under random conditions
    for (i = 0; i < 120; i++) begin
      for (t = 0; t < 4; t++) begin
        sel[t] = 6'($urandom);
        bus_wr(dofs_pkg::OFS_SEL[t], {26'h0, sel[t]});
      end
      shake(2);
      check_all();
    end
    tally_and_finish();
  end
endmodule
